// ---- src/tesio_core.sv ----
// Trigger qualification, exposure and readout sequencing, output routing, APB slave
`timescale 1ns/1ps
module tesio_core
  import tesio_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_in_iso,
  input  wire logic        trig_in_niso,
  output logic             sync_out1,
  output logic             sync_out2
);

  typedef struct packed {
    logic [31:0]  ctrl;
    logic [31:0]  delay;
    logic [31:0]  expo;
    logic [31:0]  rows;
    logic [31:0]  rowlen;
    logic [31:0]  osel;
    logic [31:0]  stb;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         swtrig;
    logic         raw_prev;
    logic [7:0]   tpd_cnt;
    logic         logic_trig;
    logic         trig_prev;
    tesio_state_e st;
    logic [31:0]  cnt;
    logic         reading;
    logic [31:0]  row_cnt;
    logic [31:0]  rows_left;
    logic [31:0]  ro_left;
    logic         stb_ev_prev;
    logic [7:0]   stb_dly;
    logic [15:0]  stb_wid;
    logic         stb_arm;
    logic         strobe;
    logic         out1;
    logic         out2;
  } tesio_s;

  tesio_s q;
  tesio_s d;

  logic        apb_acc;
  logic        apb_wr;
  logic        raw;
  logic        sel_in;
  logic        event_hit;
  logic        exposing;
  logic        imaging;
  logic        ready;
  logic        row_edge;
  logic        ro_done;
  logic [31:0] start_gap;
  logic [7:0]  tpd_cyc;
  logic [7:0]  srcv;
  logic        stb_ev;
  logic        hit;
  tesio_mode_e mode;
  tesio_src_e  src;

  // Status decode
  always_comb begin
    mode      = tesio_mode_e'(q.ctrl[TESIO_CTRL_MODE_LSB +: 2]);
    src       = tesio_src_e'(q.ctrl[TESIO_CTRL_SRC_LSB +: 2]);
    apb_acc   = psel && penable && !q.pready;
    apb_wr    = apb_acc && pwrite;
    exposing  = (q.st == TESIO_ST_EXPO);
    imaging   = exposing || q.reading;
    // Next exposure must end no earlier than the running readout
    start_gap = (q.ro_left > q.expo) ? (q.ro_left - q.expo) : 32'h0000_0000;
    row_edge  = (q.row_cnt == 32'h0000_0000);
    ready     = (q.st == TESIO_ST_WAIT) && q.ctrl[TESIO_CTRL_EN_BIT]
                && (start_gap == 32'h0000_0000);
    ro_done   = q.reading && row_edge && (q.rows_left <= 32'h0000_0001);
  end

  // Source selection and edge or level recognition
  always_comb begin
    case (src)
      TESIO_SRC_ISO:  begin sel_in = trig_in_iso;  tpd_cyc = TESIO_TPD_ISO;  end
      TESIO_SRC_NISO: begin sel_in = trig_in_niso; tpd_cyc = TESIO_TPD_NISO; end
      TESIO_SRC_SW:   begin sel_in = q.swtrig;     tpd_cyc = 8'h01;          end
      default:        begin sel_in = 1'b0;         tpd_cyc = 8'h01;          end
    endcase
    raw = sel_in;
    case (mode)
      TESIO_MODE_RISE:  event_hit = q.logic_trig && !q.trig_prev;
      TESIO_MODE_FALL:  event_hit = !q.logic_trig && q.trig_prev;
      TESIO_MODE_ANY:   event_hit = q.logic_trig != q.trig_prev;
      TESIO_MODE_LEVEL: event_hit = q.logic_trig;
      default:          event_hit = 1'b0;
    endcase
  end

  // Strobe event source and output routing values
  always_comb begin
    srcv = {!imaging, q.ctrl[TESIO_CTRL_GPO_BIT], q.strobe, imaging, q.reading,
            q.logic_trig, ready, exposing};
    stb_ev = srcv[q.stb[2:0]];
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.swtrig  = 1'b0;
    d.raw_prev = raw;
    // Logic trigger follows the input after the selected path delay
    // A one-cycle software pulse would keep reloading the counter, so it bypasses it
    if (src == TESIO_SRC_SW) begin
      d.tpd_cnt    = 8'h00;
      d.logic_trig = raw;
    end else if (raw != q.raw_prev) begin
      d.tpd_cnt = tpd_cyc;
    end else if (q.tpd_cnt != 8'h00) begin
      d.tpd_cnt = q.tpd_cnt - 8'h01;
      if (q.tpd_cnt == 8'h01) begin
        d.logic_trig = raw;
      end
    end
    d.trig_prev = q.logic_trig;
    // Row timer runs while reading out
    if (q.reading) begin
      d.row_cnt = row_edge ? (q.rowlen - 32'h0000_0001) : (q.row_cnt - 32'h0000_0001);
      if (q.ro_left != 32'h0000_0000) begin
        d.ro_left = q.ro_left - 32'h0000_0001;
      end
      if (row_edge) begin
        d.rows_left = q.rows_left - 32'h0000_0001;
      end
      if (ro_done) begin
        d.reading = 1'b0;
        d.ro_left = 32'h0000_0000;
      end
    end
    // Exposure sequencer
    case (q.st)
      TESIO_ST_WAIT: begin
        hit = event_hit && ready;
        if (hit) begin
          d.st  = TESIO_ST_DELAY;
          d.cnt = q.delay;
        end
      end
      TESIO_ST_DELAY: begin
        hit = 1'b0;
        if (q.cnt != 32'h0000_0000) begin
          d.cnt = q.cnt - 32'h0000_0001;
        end else if (!q.reading || row_edge) begin
          d.st  = TESIO_ST_EXPO;
          d.cnt = q.expo;
        end
      end
      TESIO_ST_EXPO: begin
        hit = 1'b0;
        if (q.cnt > 32'h0000_0001) begin
          d.cnt = q.cnt - 32'h0000_0001;
        end else begin
          d.st        = TESIO_ST_WAIT;
          d.reading   = 1'b1;
          d.row_cnt   = q.rowlen - 32'h0000_0001;
          d.rows_left = q.rows;
          d.ro_left   = q.rows * q.rowlen;
        end
      end
      default: begin
        hit  = 1'b0;
        d.st = TESIO_ST_WAIT;
      end
    endcase
    // Strobe pulse: delay then width after the chosen event rises
    d.stb_ev_prev = stb_ev;
    if (stb_ev && !q.stb_ev_prev && !q.stb_arm && !q.strobe) begin
      d.stb_arm = 1'b1;
      d.stb_dly = q.stb[TESIO_STB_DLY_LSB +: 8];
    end else if (q.stb_arm) begin
      if (q.stb_dly != 8'h00) begin
        d.stb_dly = q.stb_dly - 8'h01;
      end else begin
        d.stb_arm = 1'b0;
        d.strobe  = (q.stb[TESIO_STB_WID_LSB +: 16] != 16'h0000);
        d.stb_wid = q.stb[TESIO_STB_WID_LSB +: 16];
      end
    end else if (q.strobe) begin
      d.stb_wid = q.stb_wid - 16'h0001;
      if (q.stb_wid <= 16'h0001) begin
        d.strobe = 1'b0;
      end
    end
    // Output pins: select, then apply polarity
    d.out1 = srcv[q.osel[2:0]] ^ q.osel[3];
    d.out2 = srcv[q.osel[TESIO_OSEL_W +: 3]] ^ q.osel[TESIO_OSEL_W + 3];
    // APB register access, answered after one wait state
    if (apb_acc) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      case (paddr)
        TESIO_REG_CTRL:   if (apb_wr) d.ctrl   = pwdata; else d.prdata = q.ctrl;
        TESIO_REG_DELAY:  if (apb_wr) d.delay  = pwdata; else d.prdata = q.delay;
        TESIO_REG_EXPO:   if (apb_wr) d.expo   = pwdata; else d.prdata = q.expo;
        TESIO_REG_ROWS:   if (apb_wr) d.rows   = pwdata; else d.prdata = q.rows;
        TESIO_REG_ROWLEN: if (apb_wr) d.rowlen = pwdata; else d.prdata = q.rowlen;
        TESIO_REG_OUTSEL: if (apb_wr) d.osel   = pwdata; else d.prdata = q.osel;
        TESIO_REG_STROBE: if (apb_wr) d.stb    = pwdata; else d.prdata = q.stb;
        TESIO_REG_STATUS: begin
          if (apb_wr) begin
            d.pslverr = 1'b1;
          end else begin
            d.prdata = {24'h00_0000, !imaging, q.strobe, q.logic_trig, imaging,
                        q.reading, ready, exposing, q.ctrl[TESIO_CTRL_GPO_BIT]};
          end
        end
        TESIO_REG_SWTRIG: begin
          if (apb_wr) begin
            d.swtrig = pwdata[0];
          end
        end
        default: d.pslverr = 1'b1;
      endcase
    end
    if (q.rowlen == 32'h0000_0000) begin
      d.rowlen = 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q        <= '0;
      q.ctrl   <= TESIO_CTRL_RST;
      q.expo   <= TESIO_EXPO_RST;
      q.rows   <= TESIO_ROWS_RST;
      q.rowlen <= TESIO_ROWLEN_RST;
      q.osel   <= TESIO_OSEL_RST;
      q.stb    <= TESIO_STB_RST;
      q.st     <= TESIO_ST_WAIT;
    end else begin
      q <= d;
    end
  end

  // Ports from flip-flops
  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign sync_out1 = q.out1;
  assign sync_out2 = q.out2;

endmodule : tesio_core

// ---- src/tesio_pkg.sv ----
// Constants, register map and types of the trigger and exposure sync block
package tesio_pkg;
  // Register byte offsets
  localparam logic [7:0] TESIO_REG_CTRL    = 8'h00;
  localparam logic [7:0] TESIO_REG_DELAY   = 8'h04;
  localparam logic [7:0] TESIO_REG_EXPO    = 8'h08;
  localparam logic [7:0] TESIO_REG_ROWS    = 8'h0C;
  localparam logic [7:0] TESIO_REG_ROWLEN  = 8'h10;
  localparam logic [7:0] TESIO_REG_OUTSEL  = 8'h14;
  localparam logic [7:0] TESIO_REG_STROBE  = 8'h18;
  localparam logic [7:0] TESIO_REG_STATUS  = 8'h1C;
  localparam logic [7:0] TESIO_REG_SWTRIG  = 8'h20;
  // CTRL fields
  localparam int TESIO_CTRL_MODE_LSB = 0;  // 2 bits trigger mode
  localparam int TESIO_CTRL_SRC_LSB  = 2;  // 2 bits trigger source
  localparam int TESIO_CTRL_GPO_BIT  = 4;  // software output level
  localparam int TESIO_CTRL_EN_BIT   = 5;  // trigger enable
  // OUTSEL fields: out1 select [2:0], out1 invert [3], out2 select [6:4], out2 invert [7]
  localparam int TESIO_OSEL_W        = 4;
  // STROBE fields: source [2:0], delay [15:8], width [31:16]
  localparam int TESIO_STB_DLY_LSB   = 8;
  localparam int TESIO_STB_WID_LSB   = 16;
  // Reset values
  localparam logic [31:0] TESIO_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TESIO_EXPO_RST   = 32'h0000_0400;
  localparam logic [31:0] TESIO_ROWS_RST   = 32'h0000_0010;
  localparam logic [31:0] TESIO_ROWLEN_RST = 32'h0000_0040;
  localparam logic [31:0] TESIO_OSEL_RST   = 32'h0000_0010;
  localparam logic [31:0] TESIO_STB_RST    = 32'h0004_0000;
  // Trigger path delays in ns at a 125 MHz clock
  localparam int TESIO_CLK_NS      = 8;
  localparam int TESIO_TPD_ISO_NS  = 200;
  localparam int TESIO_TPD_NISO_NS = 40;
  localparam int TESIO_TPD_ISO_CYC  = TESIO_TPD_ISO_NS / TESIO_CLK_NS;
  localparam int TESIO_TPD_NISO_CYC = TESIO_TPD_NISO_NS / TESIO_CLK_NS;
  localparam logic [7:0] TESIO_TPD_ISO  = 8'(TESIO_TPD_ISO_CYC);
  localparam logic [7:0] TESIO_TPD_NISO = 8'(TESIO_TPD_NISO_CYC);
  // Trigger recognition modes
  typedef enum logic [1:0] {
    TESIO_MODE_RISE  = 2'h0,
    TESIO_MODE_FALL  = 2'h1,
    TESIO_MODE_ANY   = 2'h2,
    TESIO_MODE_LEVEL = 2'h3
  } tesio_mode_e;
  // Trigger sources
  typedef enum logic [1:0] {
    TESIO_SRC_ISO  = 2'h0,
    TESIO_SRC_NISO = 2'h1,
    TESIO_SRC_SW   = 2'h2,
    TESIO_SRC_OFF  = 2'h3
  } tesio_src_e;
  // Output signal selections
  typedef enum logic [2:0] {
    TESIO_OUT_EXPOSING = 3'h0,
    TESIO_OUT_READY    = 3'h1,
    TESIO_OUT_RELAY    = 3'h2,
    TESIO_OUT_READOUT  = 3'h3,
    TESIO_OUT_IMAGING  = 3'h4,
    TESIO_OUT_STROBE   = 3'h5,
    TESIO_OUT_GPO      = 3'h6,
    TESIO_OUT_IDLE     = 3'h7
  } tesio_osel_e;
  // Exposure sequencer states
  typedef enum logic [2:0] {
    TESIO_ST_WAIT  = 3'b001,
    TESIO_ST_DELAY = 3'b010,
    TESIO_ST_EXPO  = 3'b100
  } tesio_state_e;
endpackage : tesio_pkg

// ---- test/tesio_core_monitor.sv ----
// Port-level checker for the trigger and exposure sync block
`timescale 1ns/1ps
module tesio_core_monitor
  import tesio_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trig_in_iso,
  input wire logic        trig_in_niso,
  input wire logic        sync_out1,
  input wire logic        sync_out2
);
  logic [7:0]  osel_q;
  logic [1:0]  src_q;
  logic [31:0] expo_q;
  logic [3:0]  quiet_q;
  logic [31:0] hi_q;
  logic        wr_ok;
  logic        calm;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Accepted writes and settled configuration
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign calm  = quiet_q > 4'h2;
  // Mirror of the routing, source and exposure settings, plus a high-time counter
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      osel_q  <= 8'h10;
      src_q   <= 2'h0;
      expo_q  <= TESIO_EXPO_RST;
      quiet_q <= 4'h0;
      hi_q    <= 32'h0;
    end else begin
      if (wr_ok && paddr == TESIO_REG_OUTSEL) osel_q <= pwdata[7:0];
      if (wr_ok && paddr == TESIO_REG_CTRL) src_q <= pwdata[3:2];
      if (wr_ok && paddr == TESIO_REG_EXPO) expo_q <= pwdata;
      quiet_q <= wr_ok ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
      hi_q    <= sync_out1 ? hi_q + 32'h1 : 32'h0;
    end
  end
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus answer late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("answer held too long");
  property p_expo_len;
    calm && osel_q[3:0] == 4'h0 && $fell(sync_out1) |-> hi_q == expo_q;
  endproperty
  a_expo_len: assert property (p_expo_len) else $error("exposure width wrong");
  property p_readout_follows;
    calm && osel_q == 8'h30 && $fell(sync_out1) |-> ##[0:1] sync_out2;
  endproperty
  a_readout_follows: assert property (p_readout_follows) else $error("no readout");
  property p_imaging_idle;
    calm && osel_q == 8'hF4 |-> sync_out1 == sync_out2;
  endproperty
  a_imaging_idle: assert property (p_imaging_idle) else $error("idle mismatch");
  property p_level_polarity;
    calm && osel_q == 8'hE6 |-> sync_out1 != sync_out2;
  endproperty
  a_level_polarity: assert property (p_level_polarity) else $error("bad polarity");
  property p_relay_niso;
    calm && osel_q == 8'h20 && src_q == 2'h1 && $rose(trig_in_niso)
      |-> !sync_out2 [*5] ##[1:3] sync_out2;
  endproperty
  a_relay_niso: assert property (p_relay_niso) else $error("fast relay timing");
  property p_relay_iso;
    calm && osel_q == 8'h20 && src_q == 2'h0 && $rose(trig_in_iso)
      |-> !sync_out2 [*8] ##[18:20] sync_out2;
  endproperty
  a_relay_iso: assert property (p_relay_iso) else $error("slow relay timing");
  // Main scenarios reached
  c_readout: cover property (osel_q == 8'h30 && $fell(sync_out1));
  c_refused: cover property (pslverr);
  c_iso:     cover property (src_q == 2'h0 && $rose(trig_in_iso));
endmodule : tesio_core_monitor
bind tesio_core tesio_core_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trig_in_iso(trig_in_iso),
  .trig_in_niso(trig_in_niso), .sync_out1(sync_out1), .sync_out2(sync_out2));

// ---- test/tesio_trig_src.sv ----
// External trigger source driving both trigger pins
`timescale 1ns/1ps
module tesio_trig_src
  import tesio_pkg::*;
(
  input  wire logic ref_clk,
  output logic      trig_in_iso,
  output logic      trig_in_niso
);
  // Both pins rest low between pulses
  initial begin
    trig_in_iso  = 1'b0;
    trig_in_niso = 1'b0;
  end
  // One pulse on the chosen pin, never shorter than three trigger latencies
  task automatic pulse(input logic iso, input int hold);
    int min_hold;
    min_hold = 3 * ((iso ? TESIO_TPD_ISO_CYC : TESIO_TPD_NISO_CYC) + 4);
    if (hold < min_hold) hold = min_hold;
    @(posedge ref_clk);
    if (iso) trig_in_iso <= 1'b1;
    else trig_in_niso <= 1'b1;
    repeat (hold) @(posedge ref_clk);
    trig_in_iso  <= 1'b0;
    trig_in_niso <= 1'b0;
  endtask : pulse
endmodule : tesio_trig_src

// ---- test/trigger_exposure_sync_io_tb_top.sv ----
// Self-checking bench for the trigger and exposure sync block
`timescale 1ns/1ps
module trigger_exposure_sync_io_tb_top;
  import tesio_pkg::*;
  logic        ref_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig_in_iso;
  logic        trig_in_niso;
  logic        sync_out1;
  logic        sync_out2;
  logic [31:0] rd_v;
  logic        err_v;
  int          bad_count;
  int          comparisons;
  tesio_core dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in_iso(trig_in_iso), .trig_in_niso(trig_in_niso),
    .sync_out1(sync_out1), .sync_out2(sync_out2));
  tesio_trig_src u_src (.ref_clk(ref_clk), .trig_in_iso(trig_in_iso),
    .trig_in_niso(trig_in_niso));
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  // One bus transfer, held until the answer is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd_v    = prdata;
    err_v   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd_v === e && err_v === 1'b0, "register reset value");
  endtask : rchk
  task automatic cfg(input int ex, input int rows, input int dly, input logic [31:0] o,
                     input logic [31:0] c);
    apb(1'b1, TESIO_REG_EXPO, 32'(ex));
    apb(1'b1, TESIO_REG_ROWS, 32'(rows));
    apb(1'b1, TESIO_REG_ROWLEN, (rows == 2) ? 32'h4 : 32'hA);
    apb(1'b1, TESIO_REG_DELAY, 32'(dly));
    apb(1'b1, TESIO_REG_OUTSEL, o);
    apb(1'b1, TESIO_REG_CTRL, c);
  endtask : cfg
  // Count exposure starts seen on the first pin over n cycles
  task automatic count_expo(input int n, output int first, output int cnt);
    logic prev;
    first = -1;
    cnt   = 0;
    prev  = sync_out1;
    for (int t = 0; t < n; t++) begin
      @(posedge ref_clk);
      if (sync_out1 === 1'b1 && prev === 1'b0) begin
        cnt++;
        if (first < 0) first = t;
      end
      prev = sync_out1;
    end
  endtask : count_expo
  task automatic s_regs;
    rchk(TESIO_REG_CTRL, TESIO_CTRL_RST);
    rchk(TESIO_REG_EXPO, TESIO_EXPO_RST);
    rchk(TESIO_REG_ROWS, TESIO_ROWS_RST);
    rchk(TESIO_REG_ROWLEN, TESIO_ROWLEN_RST);
    rchk(TESIO_REG_OUTSEL, TESIO_OSEL_RST);
    rchk(TESIO_REG_STROBE, TESIO_STB_RST);
    apb(1'b0, TESIO_REG_STATUS, 32'h0);
    check(rd_v[7] === 1'b1 && rd_v[4] === 1'b0, "idle status");
    apb(1'b1, TESIO_REG_STATUS, 32'hFF);
    check(err_v === 1'b1, "status write accepted");
    apb(1'b0, 8'h30, 32'h0);
    check(err_v === 1'b1, "unmapped read accepted");
  endtask : s_regs
  task automatic s_latency;
    int f0, f1, c;
    for (int d = 0; d < 4; d += 3) begin
      cfg(8, 2, d, 32'h20, 32'h24);
      fork u_src.pulse(1'b0, 40); join_none
      count_expo(150, f0, c);
      check(c == 1 && f0 >= 8 + d && f0 <= 10 + d, "fast path latency");
      apb(1'b1, TESIO_REG_CTRL, 32'h20);
      fork u_src.pulse(1'b1, 90); join_none
      count_expo(250, f1, c);
      check(c == 1 && f1 - f0 == 20, "isolated path latency");
    end
  endtask : s_latency
  task automatic s_modes;
    int f, c;
    for (int m = 0; m < 4; m++) begin
      cfg(8, 2, 0, 32'h30, 32'h24 | 32'(m));
      fork u_src.pulse(1'b0, 100); join_none
      count_expo(300, f, c);
      check(m == 3 ? c >= 2 : c == (m == 2 ? 2 : 1), "mode count");
      if (m == 1) check(f > 100, "falling mode fired on rise");
    end
  endtask : s_modes
  task automatic s_soft;
    int f, c;
    cfg(8, 2, 0, 32'hF4, 32'h28);
    apb(1'b1, TESIO_REG_SWTRIG, 32'h1);
    count_expo(100, f, c);
    check(c == 1, "software trigger");
    fork u_src.pulse(1'b0, 30); join_none
    count_expo(100, f, c);
    check(c == 0, "unselected pin triggered");
  endtask : s_soft
  task automatic s_drop;
    int f, c;
    cfg(8, 8, 0, 32'h10, 32'h24);
    // Trigger from idle, then again mid-readout
    fork u_src.pulse(1'b0, 27); join_none
    count_expo(40, f, c);
    check(c == 1, "first trigger lost");
    check(sync_out2 === 1'b0, "ready during long readout");
    fork u_src.pulse(1'b0, 27); join_none
    count_expo(200, f, c);
    check(c == 0, "trigger queued while busy");
    check(sync_out2 === 1'b1, "not ready after readout");
  endtask : s_drop
  task automatic s_out;
    cfg(8, 2, 0, 32'hE6, 32'h10);
    repeat (3) @(posedge ref_clk);
    check(sync_out1 === 1'b1 && sync_out2 === 1'b0, "level high");
    apb(1'b1, TESIO_REG_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    check(sync_out1 === 1'b0 && sync_out2 === 1'b1, "level low");
  endtask : s_out
  task automatic s_strobe;
    int f, c;
    apb(1'b1, TESIO_REG_STROBE, 32'h0004_0200);
    cfg(8, 2, 0, 32'h05, 32'h24);
    fork u_src.pulse(1'b0, 30); join_none
    count_expo(100, f, c);
    check(c == 1 && f >= 12 && f <= 14, "strobe timing");
  endtask : s_strobe
  // Main sequence
  initial begin
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    s_regs();
    s_latency();
    s_modes();
    s_soft();
    s_drop();
    s_out();
    s_strobe();
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule : trigger_exposure_sync_io_tb_top
